// File: hw/conversion_start_strobe_port_pkg.sv
// package: constants and carrier types for the serial conversion port
package conversion_start_strobe_port_pkg;

  // ==========================================================
  // resolution and frame layout
  // ==========================================================
  localparam int unsigned RESULT_BITS    = 14;     // high-resolution variant width
  localparam int unsigned RESULT_BITS_LO = 12;     // lower-resolution variant width
  localparam int unsigned FRAME_EDGES    = 16;     // shift edges per output frame
  localparam int unsigned ACQ_OPEN_EDGE  = 16;     // edge that opens acquisition
  localparam int unsigned CONVERSION_START_STROBE_EDGES     = 18;     // edges to finish conversion
  localparam int unsigned NAP_PULSES     = 2;      // start pulses to nap
  localparam int unsigned SLEEP_PULSES   = 4;      // start pulses to sleep
  localparam int unsigned CNT_W          = 5;      // edge counter width

  // ==========================================================
  // timing: start-to-shift-edge setup
  // ==========================================================
  localparam real         SETUP_NS       = 3.0;    // least start-to-edge setup
  localparam real         CLK_NS         = 25.0;   // system clock period
  localparam int unsigned SETUP_CYC      = (SETUP_NS <= CLK_NS) ? 1 :
                                           int'((SETUP_NS + CLK_NS - 1.0) / CLK_NS);

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [RESULT_BITS-1:0] SAMPLE_RST = 14'h0000;  // held sample after reset

  // power state of the converter
  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_NAP,
    PWR_SLEEP
  } pwr_t;

  // one captured differential sample
  typedef struct packed {
    logic signed [RESULT_BITS-1:0] pos;  // noninverting input code
    logic signed [RESULT_BITS-1:0] neg;  // inverting input code
  } diff_sample_t;

  // one result word on its way to the shifter
  typedef struct packed {
    logic [RESULT_BITS-1:0] code;        // two's complement result
  } result_word_t;

endpackage : conversion_start_strobe_port_pkg

// File: hw/conversion_start_strobe_port.sv
// serial conversion port: start strobe, link shift clock, three-state result
`timescale 1ns/100ps
module conversion_start_strobe_port
  import conversion_start_strobe_port_pkg::*;
#(
  parameter bit HIGH_RES = 1'b1                           // 1: 14-bit, 0: 12-bit variant
) (
  input  wire logic                          clk_i,       // system clock, 40 MHz
  input  wire logic                          resetn_i,    // async reset, active low
  input  wire logic                          ce_i,        // clock enable, freezes clk_i-domain state only
  // analog front end, digitised, system domain
  input  wire conversion_start_strobe_port_pkg::diff_sample_t   sample_i,    // live input codes
  output logic                               hold_o,      // sample-and-hold in hold
  // link pins
  input  wire logic                          shift_clk_i, // link shift clock
  input  wire logic                          conversion_start_strobe_i, // start strobe pin
  output logic                               result_serial_out_o,       // serial data
  output logic                               result_serial_out_oe_n_o,  // low while driving
  // status
  output conversion_start_strobe_port_pkg::pwr_t                pwr_o,       // power state
  output logic                               acquire_o    // acquisition window open
);
  import conversion_start_strobe_port_pkg::*;

  // ==========================================================
  // system domain: capture the sample on each start rise
  // ==========================================================
  logic [2:0]   strobe_sync_reg;   // two-stage sync plus edge history
  logic [2:0]   strobe_sync_next;
  logic         start_rise;        // start strobe edge seen in clk_i domain
  result_word_t word_reg;          // converted word waiting for the buffer
  result_word_t word_next;
  logic         word_vld_reg;
  logic         word_vld_next;
  logic         hold_reg;          // sample-and-hold in hold
  logic         hold_next;
  logic         acq_open_reg;      // acquisition window as seen by the system side
  logic         acq_open_next;
  logic [RESULT_BITS-1:0] diff;    // differential code, two's complement
  // these three are driven further down but read here, so they are declared first
  logic         fifo_in_rdy;       // buffer not full, lets the word register drain
  logic         acq_rise;          // link domain reopened the window, clk_i view
  logic         ack_link_reg;      // link-domain acknowledge toggle

  assign start_rise = strobe_sync_reg[1] & ~strobe_sync_reg[2];

  // subtraction of both inputs taken at the same edge keeps them matched
  always_comb begin
    diff             = RESULT_BITS'(sample_i.pos - sample_i.neg);
    strobe_sync_next = {strobe_sync_reg[1:0], conversion_start_strobe_i};
    word_next        = word_reg;
    word_vld_next    = word_vld_reg;
    hold_next        = hold_reg;
    acq_open_next    = acq_open_reg;
    // the window reopens at the end of a frame; a start in the same cycle
    // overrides it below, so a conversion is never lost to the reopen
    if (acq_rise) begin
      hold_next      = 1'b0;
      acq_open_next  = 1'b1;
    end
    if (start_rise) begin
      hold_next      = 1'b1;
      acq_open_next  = 1'b0;
      // the 12-bit variant drops the two lowest bits of the 14-bit code
      word_next.code = HIGH_RES ? diff : {diff[RESULT_BITS-1 -: RESULT_BITS_LO], 2'b00};
      word_vld_next  = 1'b1;
    end else if (fifo_in_rdy) begin
      word_vld_next  = 1'b0;
    end
  end

  // registers only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strobe_sync_reg <= 3'h0;
      word_reg        <= '0;
      word_vld_reg    <= 1'b0;
      hold_reg        <= 1'b0;
      acq_open_reg    <= 1'b0;
    end else if (ce_i) begin
      strobe_sync_reg <= strobe_sync_next;
      word_reg        <= word_next;
      word_vld_reg    <= word_vld_next;
      hold_reg        <= hold_next;
      acq_open_reg    <= acq_open_next;
    end
  end
  assign hold_o = hold_reg;

  // ==========================================================
  // two-entry buffer between capture and the link handshake
  // ==========================================================
  result_word_t fifo_mem [2];      // storage, two entries
  logic [1:0]   wp_reg, wp_next;   // write pointer, bit1 is wrap
  logic [1:0]   rp_reg, rp_next;   // read pointer
  logic         fifo_out_vld;      // not empty
  logic         fifo_pop;          // link domain took the head word
  result_word_t head_reg, head_next;
  logic         ack_sync0_reg, ack_sync1_reg, ack_prev_reg; // ack toggle sync
  logic         req_reg, req_next; // request toggle toward the link

  assign fifo_in_rdy  = (wp_reg ^ rp_reg) != 2'b10;
  assign fifo_out_vld = wp_reg != rp_reg;
  assign fifo_pop     = ack_sync1_reg ^ ack_prev_reg;

  // one word in flight at a time: request toggles, link answers with ack
  always_comb begin
    wp_next   = wp_reg;
    rp_next   = rp_reg;
    req_next  = req_reg;
    head_next = head_reg;
    if (word_vld_reg && fifo_in_rdy)
      wp_next = wp_reg + 2'h1;
    if (fifo_pop)
      rp_next = rp_reg + 2'h1;
    // offer the head word when no request is outstanding
    if (fifo_out_vld && (req_reg == ack_sync1_reg) && !fifo_pop) begin
      head_next = fifo_mem[rp_reg[0]];
      req_next  = ~req_reg;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_reg        <= 2'h0;
      rp_reg        <= 2'h0;
      req_reg       <= 1'b0;
      head_reg      <= '0;
      ack_sync0_reg <= 1'b0;
      ack_sync1_reg <= 1'b0;
      ack_prev_reg  <= 1'b0;
      fifo_mem[0]   <= '0;
      fifo_mem[1]   <= '0;
    end else if (ce_i) begin
      wp_reg        <= wp_next;
      rp_reg        <= rp_next;
      req_reg       <= req_next;
      head_reg      <= head_next;
      ack_sync0_reg <= ack_link_reg;
      ack_sync1_reg <= ack_sync0_reg;
      ack_prev_reg  <= ack_sync1_reg;
      if (word_vld_reg && fifo_in_rdy)
        fifo_mem[wp_reg[0]] <= word_reg;
    end
  end

  // ==========================================================
  // link domain: everything here moves only on shift-clock rises
  // ==========================================================
  logic         start_l0_reg, start_l1_reg, start_l2_reg; // strobe sync in link domain
  logic         req_l0_reg, req_l1_reg;   // request toggle sync
  // the link side runs whenever the host clocks it; ce_i belongs to clk_i and
  // is not carried across, so a frame already started always finishes
  logic         ack_link_next;     // next acknowledge toggle
  logic [CNT_W-1:0] edge_reg, edge_next;  // edges since the start rise
  logic [RESULT_BITS-1:0] shreg_reg, shreg_next;
  logic [RESULT_BITS-1:0] pend_reg, pend_next; // word waiting for next frame
  logic         active_reg, active_next;  // a frame is being shifted
  logic         acq_reg, acq_next;        // acquisition window
  logic         link_start;

  // a start that arrives too close to an edge is caught one edge later
  assign link_start = start_l1_reg & ~start_l2_reg;

  always_comb begin
    edge_next     = edge_reg;
    shreg_next    = shreg_reg;
    pend_next     = pend_reg;
    active_next   = active_reg;
    acq_next      = acq_reg;
    ack_link_next = ack_link_reg;
    // latch a fresh word; it becomes the next frame's content
    if (req_l1_reg != ack_link_reg) begin
      pend_next     = head_reg;
      ack_link_next = req_l1_reg;
    end
    if (link_start) begin
      // frame carries the previous conversion's word
      shreg_next  = pend_reg;
      edge_next   = '0;
      active_next = 1'b1;
      acq_next    = 1'b0;
    end else if (active_reg) begin
      shreg_next = {shreg_reg[RESULT_BITS-2:0], 1'b0};
      edge_next  = edge_reg + CNT_W'(1);
      if (edge_reg == CNT_W'(ACQ_OPEN_EDGE - 1)) begin
        active_next = 1'b0;
        acq_next    = 1'b1;
      end
    end
  end

  // head_reg is stable while the toggle is outstanding, so it is safe to take
  always_ff @(posedge shift_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      start_l0_reg <= 1'b0;
      start_l1_reg <= 1'b0;
      start_l2_reg <= 1'b0;
      req_l0_reg   <= 1'b0;
      req_l1_reg   <= 1'b0;
      ack_link_reg <= 1'b0;
      edge_reg     <= '0;
      shreg_reg    <= SAMPLE_RST;
      pend_reg     <= SAMPLE_RST;
      active_reg   <= 1'b0;
      acq_reg      <= 1'b1;
    end else begin
      start_l0_reg <= conversion_start_strobe_i;
      start_l1_reg <= start_l0_reg;
      start_l2_reg <= start_l1_reg;
      req_l0_reg   <= req_reg;
      req_l1_reg   <= req_l0_reg;
      ack_link_reg <= ack_link_next;
      edge_reg     <= edge_next;
      shreg_reg    <= shreg_next;
      pend_reg     <= pend_next;
      active_reg   <= active_next;
      acq_reg      <= acq_next;
    end
  end

  // data bit from a flip-flop; released whenever no frame runs
  assign result_serial_out_o      = shreg_reg[RESULT_BITS-1];
  assign result_serial_out_oe_n_o = ~active_reg;

  // ==========================================================
  // power-down: count start rises with no shift-clock rise between
  // ==========================================================
  logic [1:0]  sck_sync_reg;       // link clock level sampled in clk_i
  logic        sck_prev_reg;
  logic        acq_s0_reg, acq_s1_reg, acq_p_reg; // window flag from the link domain
  logic [2:0]  pulses_reg, pulses_next;
  pwr_t        pwr_reg, pwr_next;

  // a shift-clock pulse shorter than about one clk_i period can slip between
  // samples; wake-up needs a pulse the system clock can see, which a host
  // clocking this slowly for power-down always gives
  assign acq_rise = acq_s1_reg & ~acq_p_reg;

  always_comb begin
    pulses_next = pulses_reg;
    pwr_next    = pwr_reg;
    if (sck_sync_reg[1] & ~sck_prev_reg) begin
      pulses_next = 3'h0;
      pwr_next    = PWR_ACTIVE;
    end else if (start_rise) begin
      if (pulses_reg != 3'h7)
        pulses_next = pulses_reg + 3'h1;
      case (pwr_reg)
        PWR_ACTIVE, PWR_NAP: begin
          if (pulses_reg + 3'h1 >= 3'(SLEEP_PULSES))
            pwr_next = PWR_SLEEP;
          else if (pulses_reg + 3'h1 >= 3'(NAP_PULSES))
            pwr_next = PWR_NAP;
        end
        PWR_SLEEP: pwr_next = PWR_SLEEP;
        default:   pwr_next = PWR_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_sync_reg <= 2'h0;
      sck_prev_reg <= 1'b0;
      acq_s0_reg   <= 1'b0;
      acq_s1_reg   <= 1'b0;
      acq_p_reg    <= 1'b0;
      pulses_reg   <= 3'h0;
      pwr_reg      <= PWR_ACTIVE;
    end else if (ce_i) begin
      sck_sync_reg <= {sck_sync_reg[0], shift_clk_i};
      sck_prev_reg <= sck_sync_reg[1];
      acq_s0_reg   <= acq_reg;
      acq_s1_reg   <= acq_s0_reg;
      acq_p_reg    <= acq_s1_reg;
      pulses_reg   <= pulses_next;
      pwr_reg      <= pwr_next;
    end
  end

  assign pwr_o     = pwr_reg;
  // the window closes on the synchronised start edge, not on the link side,
  // so it also closes for start pulses sent with the shift clock stopped
  assign acquire_o = acq_open_reg;

endmodule // conversion_start_strobe_port

// File: dv/conversion_start_strobe_port_monitor.sv
// checker: port-level timing properties of the serial conversion port
`timescale 1ns/100ps
module conversion_start_strobe_port_monitor
  import conversion_start_strobe_port_pkg::*;
(
  input wire logic                 clk_i,
  input wire logic                 resetn_i,
  input wire logic                 hold_o,
  input wire logic                 shift_clk_i,
  input wire logic                 conversion_start_strobe_i,
  input wire logic                 result_serial_out_oe_n_o,
  input wire conversion_start_strobe_port_pkg::pwr_t  pwr_o,
  input wire logic                 acquire_o
);
  // ==========================================
  // helper: shift rises seen with output driven
  // ==========================================
  logic [4:0] low_cnt_reg;   // driven rises so far
  logic [4:0] low_cnt_next;  // saturates, so a stuck driver stays caught
  always_comb begin
    low_cnt_next = result_serial_out_oe_n_o ? 5'h00 : low_cnt_reg + {4'h0, low_cnt_reg != 5'h1f};
  end
  always_ff @(posedge shift_clk_i or negedge resetn_i) begin
    if (!resetn_i) low_cnt_reg <= 5'h00;
    else low_cnt_reg <= low_cnt_next;
  end
  // ==========================================
  // properties
  // ==========================================
  property p_hold;
    @(posedge clk_i) disable iff (!resetn_i) $rose(conversion_start_strobe_i) |-> ##[1:4] hold_o;
  endproperty
  a_hold: assert property (p_hold) else $error("no hold after start");
  property p_acq_close;
    @(posedge clk_i) disable iff (!resetn_i) $rose(conversion_start_strobe_i) |-> ##6 !acquire_o;
  endproperty
  a_acq_close: assert property (p_acq_close) else $error("window open after start");
  property p_acq_excl;
    @(posedge clk_i) disable iff (!resetn_i) hold_o |-> !acquire_o;
  endproperty
  a_acq_excl: assert property (p_acq_excl) else $error("window open in hold");
  property p_nap;
    @(posedge clk_i) disable iff (!resetn_i)
      $changed(pwr_o) && pwr_o == PWR_NAP |-> $past(pwr_o) == PWR_ACTIVE;
  endproperty
  a_nap: assert property (p_nap) else $error("light power-down from wrong state");
  property p_sleep;
    @(posedge clk_i) disable iff (!resetn_i)
      $changed(pwr_o) && pwr_o == PWR_SLEEP |-> $past(pwr_o) == PWR_NAP;
  endproperty
  a_sleep: assert property (p_sleep) else $error("deep power-down too early");
  property p_wake;
    @(posedge clk_i) disable iff (!resetn_i) $rose(shift_clk_i) |-> ##[0:6] pwr_o == PWR_ACTIVE;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on shift rise");
  property p_oe_len;
    @(posedge shift_clk_i) disable iff (!resetn_i) $rose(result_serial_out_oe_n_o) |-> low_cnt_reg == 5'h10;
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("frame not 16 rises");
  property p_oe_max;
    @(posedge shift_clk_i) disable iff (!resetn_i) low_cnt_reg <= 5'h10;
  endproperty
  a_oe_max: assert property (p_oe_max) else $error("output driven too long");
  c_frame: cover property (@(posedge shift_clk_i) $rose(result_serial_out_oe_n_o));
  c_nap: cover property (@(posedge clk_i) pwr_o == PWR_NAP);
  c_sleep: cover property (@(posedge clk_i) pwr_o == PWR_SLEEP);
endmodule // conversion_start_strobe_port_monitor

bind conversion_start_strobe_port conversion_start_strobe_port_monitor mon_u (.clk_i(clk_i), .resetn_i(resetn_i), .hold_o(hold_o),
  .shift_clk_i(shift_clk_i), .conversion_start_strobe_i(conversion_start_strobe_i),
  .result_serial_out_oe_n_o(result_serial_out_oe_n_o), .pwr_o(pwr_o), .acquire_o(acquire_o));

// File: dv/conversion_start_strobe_host_model.sv
// host model: drives start strobe and shift clock, reads the serial result
`timescale 1ns/100ps
module conversion_start_strobe_host_model (
  output logic       shift_clk_o,
  output logic       strobe_o,
  input  wire logic  data_i,
  input  wire logic  oe_n_i
);
  logic        last_reg;  // released line toggles, never holds the last bit
  logic        line;      // level on the shared data wire
  logic [15:0] bits;      // frame as read, fillers included
  int          n_drv;     // read slots with the driver on
  assign line = oe_n_i ? ~last_reg : data_i;
  always @(posedge shift_clk_o) last_reg <= line;
  initial begin
    shift_clk_o = 1'b0;
    strobe_o = 1'b0;
    last_reg = 1'b0;
  end
  // one conversion: strobe, then 20 rises; clock stands still afterwards
  task automatic frame();
    bits = 16'h0000;
    n_drv = 0;
    strobe_o = 1'b1;
    #10; // strobe well ahead of the first rise
    for (int i = 1; i <= 20; i++) begin
      #15;
      if (i >= 4 && i <= 19) begin
        bits = {bits[14:0], line}; // bit caught just before the rise
        n_drv += int'(oe_n_i === 1'b0);
      end
      shift_clk_o = 1'b1;
      #15 shift_clk_o = 1'b0;
      if (i == 2) strobe_o = 1'b0;
    end
  endtask
  // start pulses with the shift clock held low
  task automatic pulses(input int n);
    repeat (n) begin
      strobe_o = 1'b1;
      #100 strobe_o = 1'b0;
      #100;
    end
  endtask
  // slow shift pulses, no strobe
  task automatic wake(input int n);
    repeat (n) begin
      #60 shift_clk_o = 1'b1;
      #60 shift_clk_o = 1'b0;
    end
  endtask
endmodule // conversion_start_strobe_host_model

// File: dv/test_conversion_start_strobe_port.sv
// testbench: conversion pipeline, frame shape and power-down states
`timescale 1ns/100ps
module test_conversion_start_strobe_port;
  import conversion_start_strobe_port_pkg::*;
  logic         clk_i = 1'b0;
  logic         resetn_i, ce_i, hold_o, sck, strobe, dout, oe_n, acq;
  logic         dout_lo, oe_n_lo;          // lower-resolution instance pins
  logic [15:0]  bits_lo = 16'h0000;        // its frame, captured on shift rises
  diff_sample_t sample_i;
  pwr_t         pwr;
  int           n_mismatch = 0;
  int           compares = 0;
  always #12.5 clk_i = ~clk_i;
  conversion_start_strobe_port dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .sample_i(sample_i),
    .hold_o(hold_o), .shift_clk_i(sck), .conversion_start_strobe_i(strobe),
    .result_serial_out_o(dout), .result_serial_out_oe_n_o(oe_n), .pwr_o(pwr), .acquire_o(acq));
  conversion_start_strobe_host_model host_u (.shift_clk_o(sck), .strobe_o(strobe), .data_i(dout), .oe_n_i(oe_n));
  // lower-resolution variant on the same inputs; its frame is read passively
  conversion_start_strobe_port #(.HIGH_RES(1'b0)) dut_lo_u (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .sample_i(sample_i), .hold_o(), .shift_clk_i(sck), .conversion_start_strobe_i(strobe),
    .result_serial_out_o(dout_lo), .result_serial_out_oe_n_o(oe_n_lo), .pwr_o(),
    .acquire_o());
  always @(posedge sck) begin
    if (!oe_n_lo) bits_lo <= {bits_lo[14:0], dout_lo};
  end
  // ==========================================
  // helpers
  // ==========================================
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic summarize();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic set_in(input logic [13:0] p, input logic [13:0] n);
    @(negedge clk_i);
    sample_i.pos = p;
    sample_i.neg = n;
  endtask
  // one frame, fillers masked off as the host drops them
  task automatic run_frame(input logic [13:0] exp, input string name);
    host_u.frame();
    chk(name, {exp, 2'b00}, {host_u.bits[15:2], 2'b00});
    chk("word_lo", {exp[13:2], 4'h0}, {bits_lo[15:2], 2'b00});
    chk("driven_rises", 16'h0010, 16'(host_u.n_drv));
    @(negedge clk_i);
    chk("released", 16'h0001, {15'h0000, oe_n});
    repeat (3) @(negedge clk_i);
    chk("acq_open", 16'h0001, {15'h0000, acq});
    chk("hold_off", 16'h0000, {15'h0000, hold_o});
  endtask
  // ==========================================
  // scenarios
  // ==========================================
  task automatic t_pipe();
    logic [13:0] p[5] = '{14'h0100, 14'h0040, 14'h1fff, 14'h0000, 14'h2000};
    logic [13:0] n[5] = '{14'h0040, 14'h0100, 14'h0000, 14'h1fff, 14'h0000};
    logic [13:0] prev;
    prev = 14'h0000; // first frame after reset shows zeros
    for (int i = 0; i < 5; i++) begin
      set_in(p[i], n[i]);
      run_frame(prev, "word");
      prev = p[i] - n[i];
    end
  endtask
  task automatic t_power();
    set_in(14'h0aaa, 14'h0155);
    host_u.pulses(2);
    chk("pwr_nap", 16'h0001, {14'h0000, pwr});
    chk("hold_pd", 16'h0001, {15'h0000, hold_o});
    chk("acq_pd", 16'h0000, {15'h0000, acq});
    host_u.pulses(2);
    chk("pwr_sleep", 16'h0002, {14'h0000, pwr});
    host_u.wake(3);
    repeat (4) @(negedge clk_i);
    chk("pwr_wake", 16'h0000, {14'h0000, pwr});
    set_in(14'h0000, 14'h0000);
    run_frame(14'h0955, "pulse_word");
  endtask
  initial begin
    resetn_i = 1'b0;
    ce_i = 1'b1;
    sample_i = '0;
    fork
      host_u.wake(2);
      repeat (12) @(negedge clk_i);
    join
    resetn_i = 1'b1;
    t_pipe();
    t_power();
    summarize();
  end
  // watchdog well past the few microseconds the scenarios need
  initial begin
    #50000;
    n_mismatch++;
    summarize();
  end
endmodule // test_conversion_start_strobe_port
